// ==== design/fcd_defs.svh ====
`ifndef FCD_DEFS_SVH
`define FCD_DEFS_SVH
// Byte offsets inside one channel window; channel n sits at n * stride
`define FCD_OFF_SIDE_A 5'h00
`define FCD_OFF_SIDE_B 5'h08
`define FCD_OFF_BLEN 5'h10
`define FCD_OFF_CTRL 5'h1c
`define FCD_OFF_STAT 5'h1e
`define FCD_CH_STRIDE 7'h20
// Control field positions
`define FCD_C_EN 0
`define FCD_C_SWREQ 1
`define FCD_C_HWEN 2
`define FCD_C_DIR 3
`define FCD_C_SIZE16 4
`define FCD_C_INDIRECT 5
`define FCD_C_CONT 6
`define FCD_C_TC_IE 7
`define FCD_C_OV_IE 8
`define FCD_C_ADJ_A 9
`define FCD_C_ADJ_B 10
`define FCD_C_STEP_A 11
`define FCD_C_STEP_B 13
// Status field positions
`define FCD_S_TERM 0
`define FCD_S_OVER 1
`define FCD_S_ACTIVE 2
// Reset values
`define FCD_CTRL_RST 16'h0000
`define FCD_ADDR_RST 24'h000000
`define FCD_BLEN_RST 16'h0000
`endif

// ==== design/fcd_pkg.sv ====
`default_nettype none
package fcd_pkg;
  typedef enum logic [5:0] {
    FCD_IDLE = 6'h01,
    FCD_BUSREQ = 6'h02,
    FCD_ARB = 6'h04,
    FCD_CYC_A = 6'h08,
    FCD_CYC_B = 6'h10,
    FCD_RELEASE = 6'h20
  } fcd_state_e;
  typedef logic [23:0] fcd_addr_t;
endpackage : fcd_pkg
`default_nettype wire

// ==== design/fcd_dma.sv ====
// Operation
// - Requests come only from on-chip peripheral lines or software bits.
// - Bus mastership is won before any transfer cycle runs.
// - Priority resolved one clock before first bus clock; channel 0 highest.
// - Peripheral acknowledge asserted during the cycle accessing that peripheral.
// - On block end update status, interrupt if enabled, then release the bus.
// - Continuous policy with request still active runs another cycle on the bus.
// - Next request sampled as acknowledge drops, then every rising edge.
// - Four identical channels 0 to 3, each with its register set.
// - Direct mode moves each item in one bus cycle without capturing data.
// - Intermittent releases bus each cycle; continuous keeps it until block end.
// - Direct rate up to one item per three clocks, or one per clock.
// - Direct mode uses side A address; direction picks read or write.
// - Size select bit chooses 8 or 16 bit items.
// - Block length counter decrements by one per item.
// - Address counters step only when their adjust enable is set.
// - Indirect mode reads into holding register, then writes next cycle.
// - Indirect rate up to one item per five clocks, or per two.
// - Indirect direction 0 reads side A, writes side B; else reversed.
// - Count reaching zero stops channel, sets both flags, clears active, interrupts.
// - Debug freeze suspends all transfer activity until it drops.
// - Software request bit set means an active request for that channel.
//
// Implementation choices: the address map and the address-and-strobe port.
`include "fcd_defs.svh"
`default_nettype none
module fcd_dma #(
  parameter int NUM_CH = 4
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [6:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [3:0] periph_req,
  output logic [3:0] periph_ack,
  input wire logic freeze,
  output logic bus_req,
  input wire logic bus_grant,
  output logic [23:0] bus_addr,
  output logic bus_rd,
  output logic bus_wr,
  output logic bus_size16,
  output logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  output logic [3:0] chan_irq
);
  fcd_pkg::fcd_state_e state_reg, state_next;
  logic [1:0] cur_ch_reg, ch_next;
  logic [15:0] channel_control_reg [NUM_CH];
  fcd_pkg::fcd_addr_t side_a_address_counter [NUM_CH];
  fcd_pkg::fcd_addr_t side_b_address_counter [NUM_CH];
  logic [15:0] block_length_counter [NUM_CH];
  logic [NUM_CH-1:0] terminal_count_flag_reg, overrun_flag_reg, channel_active_flag_reg;
  logic [NUM_CH-1:0] req_vec;
  logic [1:0] prio_ch;
  logic [15:0] cur_ctrl, nctrl;
  logic [15:0] blen_cur;
  fcd_pkg::fcd_addr_t a_cur, a_upd, b_upd, a_use, b_use;
  logic cur_ind, last_item, item_done, term, cont_go;
  logic cyc_a, cyc_b, side_a_cyc, strobe_live, live_next;
  logic [1:0] wch;
  logic [4:0] woff;

  function automatic fcd_pkg::fcd_addr_t fcd_step(
    input fcd_pkg::fcd_addr_t a,
    input logic en,
    input logic [1:0] f
  );
    fcd_pkg::fcd_addr_t mag;
    mag = f[0] ? 24'h000002 : 24'h000001;
    if (!en)
      return a;
    return f[1] ? a - mag : a + mag;
  endfunction : fcd_step

  assign wch = reg_addr[6:5];
  assign woff = reg_addr[4:0];
  assign cur_ctrl = channel_control_reg[cur_ch_reg];
  assign blen_cur = block_length_counter[cur_ch_reg];
  assign a_cur = side_a_address_counter[cur_ch_reg];
  assign cur_ind = cur_ctrl[`FCD_C_INDIRECT];
  assign last_item = blen_cur == 16'h0001;
  // A cycle cut by the halt still showed its strobe but is not counted, so it is reissued
  assign strobe_live = bus_rd || bus_wr;

  always_comb
  begin
    for (int n = 0; n < NUM_CH; n++)
      req_vec[n] = channel_control_reg[n][`FCD_C_EN] && (block_length_counter[n] != 16'h0000) &&
        (channel_control_reg[n][`FCD_C_SWREQ] ||
        (channel_control_reg[n][`FCD_C_HWEN] && periph_req[n]));
  end

  always_comb
  begin
    prio_ch = 2'h0;
    for (int n = NUM_CH - 1; n >= 0; n--)
      if (req_vec[n])
        prio_ch = 2'(n);
  end

  assign a_upd = fcd_step(a_cur, cur_ctrl[`FCD_C_ADJ_A], cur_ctrl[`FCD_C_STEP_A +: 2]);
  assign b_upd = cur_ind ? fcd_step(side_b_address_counter[cur_ch_reg], cur_ctrl[`FCD_C_ADJ_B],
    cur_ctrl[`FCD_C_STEP_B +: 2]) : side_b_address_counter[cur_ch_reg];

  assign item_done = !freeze && strobe_live && ((state_reg == fcd_pkg::FCD_CYC_A && !cur_ind) ||
    state_reg == fcd_pkg::FCD_CYC_B);
  assign term = item_done && last_item;
  // request resampled as this cycle ends
  assign cont_go = cur_ctrl[`FCD_C_CONT] && req_vec[cur_ch_reg];

  always_comb
  begin
    state_next = state_reg;
    ch_next = cur_ch_reg;
    if (!freeze)
    begin
      unique case (state_reg)
        fcd_pkg::FCD_IDLE:
          if (|req_vec)
            state_next = fcd_pkg::FCD_BUSREQ;
        fcd_pkg::FCD_BUSREQ:
          if (bus_grant)
            state_next = fcd_pkg::FCD_ARB;
        // resolve one clock before first bus clock
        fcd_pkg::FCD_ARB:
          if (|req_vec)
          begin
            ch_next = prio_ch;
            state_next = fcd_pkg::FCD_CYC_A;
          end
          else
            state_next = fcd_pkg::FCD_RELEASE;
        // direct done here, indirect goes on to write
        fcd_pkg::FCD_CYC_A:
          if (strobe_live && cur_ind)
            state_next = fcd_pkg::FCD_CYC_B;
          else if (strobe_live && (term || !cont_go))
            state_next = fcd_pkg::FCD_RELEASE;
        fcd_pkg::FCD_CYC_B:
          if (strobe_live)
            state_next = (term || !cont_go) ? fcd_pkg::FCD_RELEASE : fcd_pkg::FCD_CYC_A;
        fcd_pkg::FCD_RELEASE:
          state_next = fcd_pkg::FCD_IDLE;
        default:
          state_next = fcd_pkg::FCD_IDLE;
      endcase
    end
  end

  // Next cycle uses stepped counters when an item just completed
  assign nctrl = channel_control_reg[ch_next];
  assign a_use = item_done ? a_upd : side_a_address_counter[ch_next];
  assign b_use = item_done ? b_upd : side_b_address_counter[ch_next];
  assign cyc_a = state_next == fcd_pkg::FCD_CYC_A;
  assign cyc_b = state_next == fcd_pkg::FCD_CYC_B;
  assign side_a_cyc = cyc_a ? !(nctrl[`FCD_C_INDIRECT] && nctrl[`FCD_C_DIR]) :
    (cyc_b && nctrl[`FCD_C_DIR]);
  assign live_next = !freeze && (cyc_a || cyc_b);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_reg <= fcd_pkg::FCD_IDLE;
      cur_ch_reg <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      cur_ch_reg <= ch_next;
    end
  end

  // Bus outputs registered from next state so they align with the state
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      bus_req <= 1'b0;
      bus_addr <= `FCD_ADDR_RST;
      bus_rd <= 1'b0;
      bus_wr <= 1'b0;
      bus_size16 <= 1'b0;
      periph_ack <= 4'h0;
    end
    else
    begin
      // request held from the bus request state until release
      bus_req <= state_next != fcd_pkg::FCD_IDLE && state_next != fcd_pkg::FCD_RELEASE;
      bus_addr <= live_next ? (side_a_cyc ? a_use : b_use) : `FCD_ADDR_RST;
      bus_rd <= !freeze && cyc_a && (nctrl[`FCD_C_INDIRECT] || !nctrl[`FCD_C_DIR]);
      bus_wr <= !freeze && (cyc_b || (cyc_a && !nctrl[`FCD_C_INDIRECT] && nctrl[`FCD_C_DIR]));
      bus_size16 <= live_next && nctrl[`FCD_C_SIZE16];
      // acknowledge only in the side A cycle of a hardware request
      periph_ack <= (!freeze && side_a_cyc && nctrl[`FCD_C_HWEN] && !nctrl[`FCD_C_SWREQ]) ?
        4'(1 << ch_next) : 4'h0;
    end
  end

  // holding register doubles as write data; direct mode never captures
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      bus_wdata <= 16'h0000;
    else if (!freeze && state_reg == fcd_pkg::FCD_CYC_A && cur_ind && bus_rd)
      bus_wdata <= cur_ctrl[`FCD_C_SIZE16] ? bus_rdata : {8'h00, bus_rdata[7:0]};
  end

  // per-channel registers; hardware update wins over a same-cycle write
  always_ff @(posedge ref_clk)
  begin
    for (int n = 0; n < NUM_CH; n++)
    begin
      if (srst)
      begin
        channel_control_reg[n] <= `FCD_CTRL_RST;
        side_a_address_counter[n] <= `FCD_ADDR_RST;
        side_b_address_counter[n] <= `FCD_ADDR_RST;
        block_length_counter[n] <= `FCD_BLEN_RST;
      end
      else
      begin
        if (reg_wr && wch == 2'(n))
        begin
          unique case (woff)
            `FCD_OFF_SIDE_A: side_a_address_counter[n] <= reg_wdata[23:0];
            `FCD_OFF_SIDE_B: side_b_address_counter[n] <= reg_wdata[23:0];
            `FCD_OFF_BLEN: block_length_counter[n] <= reg_wdata[15:0];
            `FCD_OFF_CTRL: channel_control_reg[n] <= reg_wdata[15:0];
            default: ;
          endcase
        end
        if (item_done && cur_ch_reg == 2'(n))
        begin
          side_a_address_counter[n] <= a_upd;
          side_b_address_counter[n] <= b_upd;
          block_length_counter[n] <= blen_cur - 16'h0001;
        end
        if (term && cur_ch_reg == 2'(n))
          channel_control_reg[n][`FCD_C_EN] <= 1'b0;
      end
    end
  end

  // Status: write one to clear, hardware set wins
  always_ff @(posedge ref_clk)
  begin
    for (int n = 0; n < NUM_CH; n++)
    begin
      if (srst)
      begin
        terminal_count_flag_reg[n] <= 1'b0;
        overrun_flag_reg[n] <= 1'b0;
        channel_active_flag_reg[n] <= 1'b0;
      end
      else
      begin
        if (reg_wr && wch == 2'(n) && woff == `FCD_OFF_STAT)
        begin
          if (reg_wdata[`FCD_S_TERM])
            terminal_count_flag_reg[n] <= 1'b0;
          if (reg_wdata[`FCD_S_OVER])
            overrun_flag_reg[n] <= 1'b0;
        end
        if (!freeze && state_reg == fcd_pkg::FCD_ARB && |req_vec && prio_ch == 2'(n))
          channel_active_flag_reg[n] <= 1'b1;
        if (term && cur_ch_reg == 2'(n))
        begin
          terminal_count_flag_reg[n] <= 1'b1;
          overrun_flag_reg[n] <= 1'b1;
          channel_active_flag_reg[n] <= 1'b0;
        end
      end
    end
  end

  // interrupt when either flag is set together with its enable
  always_ff @(posedge ref_clk)
  begin
    for (int n = 0; n < NUM_CH; n++)
    begin
      if (srst)
        chan_irq[n] <= 1'b0;
      else
        chan_irq[n] <= (terminal_count_flag_reg[n] && channel_control_reg[n][`FCD_C_TC_IE]) ||
          (overrun_flag_reg[n] && channel_control_reg[n][`FCD_C_OV_IE]);
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (srst || !reg_rd)
      reg_rdata <= 32'h00000000;
    else
    begin
      unique case (woff)
        `FCD_OFF_SIDE_A: reg_rdata <= {8'h00, side_a_address_counter[wch]};
        `FCD_OFF_SIDE_B: reg_rdata <= {8'h00, side_b_address_counter[wch]};
        `FCD_OFF_BLEN: reg_rdata <= {16'h0000, block_length_counter[wch]};
        `FCD_OFF_CTRL: reg_rdata <= {16'h0000, channel_control_reg[wch]};
        `FCD_OFF_STAT: reg_rdata <= {29'h00000000, channel_active_flag_reg[wch],
          overrun_flag_reg[wch], terminal_count_flag_reg[wch]};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  cycle_after_arb_a: assert property (
    $rose(state_reg == fcd_pkg::FCD_CYC_A) |-> $past(state_reg == fcd_pkg::FCD_ARB) ||
      $past(state_reg == fcd_pkg::FCD_CYC_B))
    else $error("transfer cycle without arbitration");

  prio_chan_zero_a: assert property (
    state_reg == fcd_pkg::FCD_ARB && !freeze && req_vec[0] |=> cur_ch_reg == 2'h0 && bus_req)
    else $error("channel 0 not chosen first");

  ack_in_cycle_a: assert property (
    |periph_ack |-> (bus_rd || bus_wr) && $onehot(periph_ack))
    else $error("acknowledge outside a bus cycle");

  term_release_a: assert property (
    term |=> state_reg == fcd_pkg::FCD_RELEASE && !bus_req ##1 state_reg == fcd_pkg::FCD_IDLE)
    else $error("bus not released after block end");

  intermittent_release_a: assert property (
    item_done && !cur_ctrl[`FCD_C_CONT] |=> !bus_req && !bus_rd && !bus_wr)
    else $error("intermittent policy kept the bus");

  blen_decrement_a: assert property (
    item_done && !(reg_wr && woff == `FCD_OFF_BLEN) |=> blen_cur == $past(blen_cur) - 16'h0001)
    else $error("block length not decremented by one");

  addr_frozen_a: assert property (
    item_done && !cur_ctrl[`FCD_C_ADJ_A] && !reg_wr |=> a_cur == $past(a_cur))
    else $error("side A address moved while frozen");

  indirect_two_a: assert property (
    state_reg == fcd_pkg::FCD_CYC_A && cur_ind && bus_rd && !freeze |=> bus_wr && !bus_rd ##0
      state_reg == fcd_pkg::FCD_CYC_B)
    else $error("indirect item not two bus cycles");

  term_flags_a: assert property (
    term |=> terminal_count_flag_reg[cur_ch_reg] && overrun_flag_reg[cur_ch_reg] &&
      !channel_active_flag_reg[cur_ch_reg] && !channel_control_reg[cur_ch_reg][`FCD_C_EN])
    else $error("termination flags wrong");

  freeze_hold_a: assert property (
    freeze |=> state_reg == $past(state_reg) && !bus_rd && !bus_wr)
    else $error("activity during freeze");
endmodule : fcd_dma
`default_nettype wire

// ==== design/fcd_unused_placeholder_none.sv ====
`default_nettype none
`default_nettype wire

// ==== bench/fcd_bus_model.sv ====
`default_nettype none
// Bus arbiter and memory on the far side of the system bus
module fcd_bus_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [1:0] grant_wait,
  input wire logic bus_req,
  output logic bus_grant,
  input wire logic [23:0] bus_addr,
  input wire logic bus_rd,
  output logic [15:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_cnt;
  logic [15:0] last_rdata;
  // Slow grants exercise the wait in the bus request state
  always_ff @(posedge ref_clk)
  begin
    if (srst || !bus_req)
    begin
      wait_cnt <= 2'h0;
      bus_grant <= 1'b0;
    end
    else if (wait_cnt != grant_wait)
      wait_cnt <= wait_cnt + 2'h1;
    else
      bus_grant <= 1'b1;
  end
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      last_rdata <= 16'h0000;
    else if (bus_rd)
      last_rdata <= bus_rdata;
  end
  // Released data lines show the inverse, so a late capture is caught
  assign bus_rdata = bus_rd ? (bus_addr[15:0] ^ 16'h5a5a) : ~last_rdata;
endmodule : fcd_bus_model
`default_nettype wire

// ==== bench/tb.sv ====
`include "fcd_defs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [15:0] ctrl; logic [3:0] blen; logic hw; logic [1:0] gw;} fcd_row_s;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [6:0] reg_addr = 7'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic freeze = 1'b0;
  logic [3:0] periph_req = 4'h0;
  logic [1:0] grant_wait = 2'h0;
  logic [31:0] reg_rdata;
  logic [3:0] periph_ack, chan_irq;
  logic bus_req, bus_grant, bus_rd, bus_wr, bus_size16;
  logic [23:0] bus_addr, a_rd, a_wr;
  logic [15:0] bus_wdata, bus_rdata, w_last;
  int errors = 0, tests_run = 0, cyc = 0, n_rd, n_wr, n_sz, n_ack, t_first = -1, t_last;
  fcd_row_s rows [5] = '{'{16'h0200, 3, 0, 0}, '{16'h0ad8, 4, 0, 1}, '{16'h3720, 2, 0, 2},
    '{16'h6678, 3, 0, 3}, '{16'h0044, 3, 1, 0}};

  always #12.5 ref_clk = ~ref_clk;

  fcd_dma u_fcd_dma (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .periph_req,
    .periph_ack, .freeze, .bus_req, .bus_grant, .bus_addr, .bus_rd, .bus_wr, .bus_size16, .bus_wdata,
    .bus_rdata, .chan_irq);
  fcd_bus_model u_fcd_bus_model (.ref_clk, .srst, .grant_wait, .bus_req, .bus_grant, .bus_addr, .bus_rd,
    .bus_rdata);

  always @(posedge ref_clk)
  begin
    cyc++;
    if (bus_rd)
    begin
      if (n_rd == 0)
        a_rd = bus_addr;
      n_rd++;
    end
    if (bus_wr)
    begin
      if (n_wr == 0)
        a_wr = bus_addr;
      n_wr++;
      w_last = bus_wdata;
    end
    if (bus_rd || bus_wr)
    begin
      if (t_first < 0)
        t_first = cyc;
      t_last = cyc;
      if (bus_size16 === 1'b1)
        n_sz++;
    end
    if (periph_ack === 4'h1)
      n_ack++;
  end

  task automatic results();
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [1:0] ch, input logic [4:0] off, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= {ch, off};
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] ch, input logic [4:0] off, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= {ch, off};
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask : rd

  task automatic rchk(input string name, input logic [1:0] ch, input logic [4:0] off, input logic [31:0] exp);
    logic [31:0] d;
    rd(ch, off, d);
    chk(name, d, exp);
  endtask : rchk

  task automatic wait_term(input logic [1:0] ch);
    logic [31:0] d;
    d = 32'h0;
    for (int i = 0; i < 100 && d[0] !== 1'b1; i++)
      rd(ch, `FCD_OFF_STAT, d);
    if (d[0] !== 1'b1)
    begin
      errors++;
      results();
    end
  endtask : wait_term

  task automatic clr_mon();
    n_rd = 0;
    n_wr = 0;
    n_sz = 0;
    n_ack = 0;
    t_first = -1;
  endtask : clr_mon

  function automatic fcd_pkg::fcd_addr_t adv(input fcd_pkg::fcd_addr_t a, input logic [1:0] code,
    input logic adj, input int k);
    fcd_pkg::fcd_addr_t d;
    d = fcd_pkg::fcd_addr_t'(k * (code[0] ? 2 : 1));
    return !adj ? a : code[1] ? a - d : a + d;
  endfunction : adv

  initial
  begin
    logic [15:0] c;
    fcd_pkg::fcd_addr_t a0, b0, src, last;
    int n;
    logic ind, dir;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      rchk("ctrl", k[1:0], `FCD_OFF_CTRL, 32'h0);
      rchk("status", k[1:0], `FCD_OFF_STAT, 32'h0);
      wr(k[1:0], `FCD_OFF_SIDE_A, 32'ha000 + k);
    end
    for (int k = 0; k < 4; k++)
      rchk("side a own", k[1:0], `FCD_OFF_SIDE_A, 32'ha000 + k);
    chk("bus_req idle", bus_req, 32'h0);
    foreach (rows[r])
    begin
      c = rows[r].ctrl;
      n = rows[r].blen;
      ind = c[`FCD_C_INDIRECT];
      dir = c[`FCD_C_DIR];
      a0 = 24'h040000 + 24'(r * 256);
      b0 = 24'h080000 + 24'(r * 256);
      grant_wait <= rows[r].gw;
      wr(0, `FCD_OFF_CTRL, 32'h0);
      wr(0, `FCD_OFF_SIDE_A, a0);
      wr(0, `FCD_OFF_SIDE_B, b0);
      wr(0, `FCD_OFF_BLEN, n);
      clr_mon();
      periph_req <= {3'h0, rows[r].hw};
      wr(0, `FCD_OFF_CTRL, c | (rows[r].hw ? 16'h1 : 16'h3));
      wait_term(0);
      periph_req <= 4'h0;
      rchk("side a", 0, `FCD_OFF_SIDE_A, adv(a0, c[12:11], c[9], n));
      rchk("side b", 0, `FCD_OFF_SIDE_B, ind ? adv(b0, c[14:13], c[10], n) : b0);
      rchk("blen", 0, `FCD_OFF_BLEN, 32'h0);
      rchk("status end", 0, `FCD_OFF_STAT, 32'h3);
      chk("irq", chan_irq[0], c[7] | c[8]);
      chk("reads", n_rd, (ind || !dir) ? n : 0);
      chk("writes", n_wr, (ind || dir) ? n : 0);
      chk("size16", n_sz, c[`FCD_C_SIZE16] ? n * (ind ? 2 : 1) : 0);
      chk("acks", n_ack, rows[r].hw ? n : 0);
      src = dir ? b0 : a0;
      last = dir ? adv(b0, c[14:13], c[10], n - 1) : adv(a0, c[12:11], c[9], n - 1);
      if (ind)
      begin
        chk("first read", a_rd, src);
        chk("first write", a_wr, dir ? a0 : b0);
        chk("held data", w_last, c[`FCD_C_SIZE16] ? last[15:0] ^ 16'h5a5a : {8'h00, last[7:0] ^ 8'h5a});
      end
      else
        chk("direct addr", dir ? a_wr : a_rd, a0);
      if (c[`FCD_C_CONT])
        chk("burst span", t_last - t_first, n * (ind ? 2 : 1) - 1);
      else
        chk("spacing", (t_last - t_first) >= (n - 1) * (ind ? 5 : 3), 1);
      wr(0, `FCD_OFF_STAT, 32'h3);
      rchk("status clear", 0, `FCD_OFF_STAT, 32'h0);
      chk("irq off", chan_irq[0], 32'h0);
    end
    // Both channels wait behind the halt so arbitration sees them together
    @(posedge ref_clk);
    freeze <= 1'b1;
    wr(2, `FCD_OFF_SIDE_A, 32'h0c0000);
    wr(1, `FCD_OFF_SIDE_A, 32'h0b0000);
    wr(2, `FCD_OFF_BLEN, 32'h1);
    wr(1, `FCD_OFF_BLEN, 32'h1);
    wr(2, `FCD_OFF_CTRL, 32'h3);
    wr(1, `FCD_OFF_CTRL, 32'h3);
    repeat (8) @(posedge ref_clk);
    chk("halted", bus_req, 32'h0);
    clr_mon();
    freeze <= 1'b0;
    wait_term(1);
    wait_term(2);
    chk("priority", a_rd, 32'h0c0000 - 32'h010000);
    chk("both served", n_rd, 2);
    // Halt in mid-burst: the cut cycle is reissued, no item lost or doubled
    wr(0, `FCD_OFF_SIDE_A, 32'h0d0000);
    wr(0, `FCD_OFF_BLEN, 32'h6);
    clr_mon();
    wr(0, `FCD_OFF_CTRL, 32'h0243);
    repeat (6) @(posedge ref_clk);
    freeze <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("halt strobe", bus_rd, 32'h0);
    chk("halt holds bus", bus_req, 32'h1);
    freeze <= 1'b0;
    wait_term(0);
    chk("halt cycles", n_rd, 7);
    rchk("halt side a", 0, `FCD_OFF_SIDE_A, 32'h0d0006);
    rchk("halt blen", 0, `FCD_OFF_BLEN, 32'h0);
    wr(3, `FCD_OFF_CTRL, 32'h3);
    repeat (6) @(posedge ref_clk);
    chk("zero length", bus_req, 32'h0);
    // Reset in mid-burst leaves every channel idle
    wr(1, `FCD_OFF_BLEN, 32'h8);
    wr(1, `FCD_OFF_CTRL, 32'h43);
    repeat (5) @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rchk("reset ctrl", 1, `FCD_OFF_CTRL, 32'h0);
    rchk("reset blen", 1, `FCD_OFF_BLEN, 32'h0);
    rchk("reset status", 1, `FCD_OFF_STAT, 32'h0);
    chk("reset bus", bus_req, 32'h0);
    chk("reset irq", chan_irq, 32'h0);
    results();
  end
endmodule : tb
`default_nettype wire
